// File: core/dbsp_port.v
// dual sensor-bus master: serial host port, per-channel buffers, crc and pacing
`include "dbsp_defines.vh"
module dbsp_port #(
  parameter CHANNELS   = `DBSP_CHANNELS,
  parameter FIFO_DEPTH = `DBSP_FIFO_DEPTH,
  parameter FIFO_AW    = `DBSP_FIFO_AW,
  parameter [7:0] CRC_POLY   = `DBSP_CRC_POLY,
  parameter [7:0] BIT_PERIOD = `DBSP_BIT_PERIOD
) (
  input  wire                          REF_CLK_IN,
  input  wire                          NRST_IN,
  input  wire                          CE_IN,
  input  wire                          CS_N_IN,
  input  wire                          SCLK_IN,
  input  wire                          MOSI_IN,
  output reg                           MISO_OUT,
  output reg                           MISO_OE_OUT,
  output reg                           IRQ_N_OUT,
  output reg                           IRQ_OE_OUT,
  input  wire [5*CHANNELS-1:0]         MSG_LEN_IN,
  input  wire [4*CHANNELS-1:0]         CRC_LEN_IN,
  input  wire [CHANNELS-1:0]           SPREAD_EN_IN,
  input  wire [CHANNELS-1:0]           SEND_MASK_IN,
  input  wire [CHANNELS-1:0]           RECV_MASK_IN,
  output reg  [24*CHANNELS-1:0]        TX_DATA_OUT,
  output reg  [CHANNELS-1:0]           TX_VALID_OUT,
  input  wire [CHANNELS-1:0]           TX_READY_IN,
  input  wire [24*CHANNELS-1:0]        RX_DATA_IN,
  input  wire [CHANNELS-1:0]           RX_VALID_IN,
  output wire [CHANNELS-1:0]           RX_READY_OUT
);
  // crc over the low mlen message bits, msb first, poly trimmed to clen bits
  function [7:0] crc_calc;
    input [15:0] msg;
    input [4:0]  mlen;
    input [3:0]  clen;
    reg   [7:0]  crc;
    reg   [7:0]  mask;
    reg          fb;
    integer      k;
    begin
      crc  = 8'h00;
      mask = (clen >= `DBSP_CRC_MAX) ? 8'hff : ((8'h01 << clen) - 8'h01);
      fb   = 1'b0;
      for (k = 15; k >= 0; k = k - 1) begin
        if (k < mlen && clen != 4'h0) begin
          fb  = crc[clen-1] ^ msg[k];
          crc = ((crc << 1) ^ (fb ? CRC_POLY : 8'h00)) & mask;
        end
      end
      crc_calc = crc;
    end
  endfunction

  // pin synchronisers
  reg [2:0] cs_sync;
  reg [2:0] sclk_sync;
  reg [1:0] mosi_sync;
  always @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cs_sync   <= 3'h7;
      sclk_sync <= 3'h0;
      mosi_sync <= 2'h0;
    end else if (CE_IN) begin
      cs_sync   <= {cs_sync[1:0], CS_N_IN};
      sclk_sync <= {sclk_sync[1:0], SCLK_IN};
      mosi_sync <= {mosi_sync[0], MOSI_IN};
    end
  end
  wire cs_low   = ~cs_sync[1];
  wire cs_fall  = cs_sync[2] & ~cs_sync[1];
  wire cs_rise  = ~cs_sync[2] & cs_sync[1];
  wire sclk_up  = cs_low & ~sclk_sync[2] & sclk_sync[1];
  wire sclk_dn  = cs_low & sclk_sync[2] & ~sclk_sync[1];

  // per-channel buffer wiring
  wire [CHANNELS-1:0]    txf_in_ready;
  wire [CHANNELS-1:0]    txf_out_valid;
  wire [CHANNELS-1:0]    txf_pop;
  wire [16*CHANNELS-1:0] txf_data;
  wire [CHANNELS-1:0]    rxf_out_valid;
  wire [CHANNELS-1:0]    rxf_pop;
  wire [16*CHANNELS-1:0] rxf_data;
  reg  [CHANNELS-1:0]    crc_err;
  reg  [CHANNELS-1:0]    push_tx;
  reg  [CHANNELS-1:0]    pop_rx;

  // serial transaction state
  reg [7:0]  shift_in;
  reg [7:0]  shift_out;
  reg [2:0]  bit_cnt;
  reg [1:0]  byte_cnt;
  reg [7:0]  cmd;
  reg [15:0] wdata;
  wire       chan = cmd[`DBSP_CMD_CHAN_BIT];
  wire [7:0] next_byte = {shift_in[6:0], mosi_sync[1]};
  wire [7:0] status = {crc_err[1:0], rxf_out_valid[1:0], ~txf_in_ready[1:0], ~txf_out_valid[1:0]};
  wire [15:0] rd_word = chan ? rxf_data[31:16] : rxf_data[15:0];

  always @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      shift_in    <= 8'h00;
      shift_out   <= 8'h00;
      bit_cnt     <= 3'h0;
      byte_cnt    <= 2'h0;
      cmd         <= 8'h00;
      wdata       <= 16'h0000;
      MISO_OUT    <= 1'b0;
      MISO_OE_OUT <= 1'b0;
      push_tx     <= {CHANNELS{1'b0}};
      pop_rx      <= {CHANNELS{1'b0}};
    end else if (CE_IN) begin
      push_tx     <= {CHANNELS{1'b0}};
      pop_rx      <= {CHANNELS{1'b0}};
      MISO_OE_OUT <= cs_low;
      if (cs_fall) begin
        bit_cnt   <= 3'h0;
        byte_cnt  <= 2'h0;
        cmd       <= 8'h00;
        MISO_OUT  <= status[7];
        shift_out <= {status[6:0], 1'b0};
      end else if (cs_rise) begin
        if (byte_cnt == `DBSP_FRAME_BYTES) begin
          if (cmd[`DBSP_CMD_WRITE_BIT]) begin
            push_tx[chan] <= 1'b1;
          end else begin
            pop_rx[chan] <= 1'b1;
          end
        end
      end else if (sclk_up) begin
        shift_in <= next_byte;
        bit_cnt  <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7 && byte_cnt != `DBSP_FRAME_BYTES) begin
          byte_cnt <= byte_cnt + 2'h1;
          case (byte_cnt)
            2'h0: begin
              cmd       <= next_byte;
              shift_out <= next_byte[`DBSP_CMD_CHAN_BIT] ? rxf_data[31:24] : rxf_data[15:8];
            end
            2'h1: begin
              wdata[15:8] <= next_byte;
              shift_out   <= rd_word[7:0];
            end
            2'h2: begin
              wdata[7:0] <= next_byte;
              shift_out  <= 8'h00;
            end
            default: begin
              shift_out <= 8'h00;
            end
          endcase
        end
      end else if (sclk_dn) begin
        MISO_OUT  <= shift_out[7];
        shift_out <= {shift_out[6:0], 1'b0};
      end
    end
  end

  // interrupt: level of any enabled send or receive condition
  always @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      IRQ_N_OUT  <= 1'b0;
      IRQ_OE_OUT <= 1'b0;
    end else if (CE_IN) begin
      IRQ_N_OUT  <= 1'b0;
      IRQ_OE_OUT <= |((~txf_out_valid & ~TX_VALID_OUT & SEND_MASK_IN) |
                       ((rxf_out_valid | crc_err) & RECV_MASK_IN));
    end
  end

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : ch
      wire [4:0]  mlen_raw = MSG_LEN_IN[5*g+4:5*g];
      wire [3:0]  clen_raw = CRC_LEN_IN[4*g+3:4*g];
      wire [4:0]  mlen = (mlen_raw < `DBSP_MSG_MIN) ? `DBSP_MSG_MIN :
                         (mlen_raw > `DBSP_MSG_MAX) ? `DBSP_MSG_MAX : mlen_raw;
      wire [3:0]  clen = (clen_raw > `DBSP_CRC_MAX) ? `DBSP_CRC_MAX : clen_raw;
      wire [15:0] tx_msg = txf_data[16*g+15:16*g];
      wire [15:0] rx_msg = RX_DATA_IN[24*g+23:24*g+8];
      wire [7:0]  rx_crc = RX_DATA_IN[24*g+7:24*g];
      wire        rx_push = RX_VALID_IN[g] & RX_READY_OUT[g];
      reg  [7:0]  lfsr;
      reg  [7:0]  pace;
      wire        tick = (pace == 8'h00);
      wire        take = tick & txf_out_valid[g] & (~TX_VALID_OUT[g] | TX_READY_IN[g]);
      assign txf_pop[g] = take;
      assign rxf_pop[g] = pop_rx[g];

      dbsp_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_txf (
        .clk_in        (REF_CLK_IN),
        .rst_n_in      (NRST_IN),
        .en_in         (CE_IN),
        .in_valid_in   (push_tx[g]),
        .in_ready_out  (txf_in_ready[g]),
        .in_data_in    (wdata),
        .out_valid_out (txf_out_valid[g]),
        .out_ready_in  (txf_pop[g]),
        .out_data_out  (txf_data[16*g+15:16*g])
      );
      dbsp_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rxf (
        .clk_in        (REF_CLK_IN),
        .rst_n_in      (NRST_IN),
        .en_in         (CE_IN),
        .in_valid_in   (RX_VALID_IN[g]),
        .in_ready_out  (RX_READY_OUT[g]),
        .in_data_in    (rx_msg),
        .out_valid_out (rxf_out_valid[g]),
        .out_ready_in  (rxf_pop[g]),
        .out_data_out  (rxf_data[16*g+15:16*g])
      );

      always @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
          lfsr                    <= `DBSP_LFSR_SEED;
          pace                    <= 8'h00;
          crc_err[g]              <= 1'b0;
          TX_VALID_OUT[g]         <= 1'b0;
          TX_DATA_OUT[24*g+23:24*g] <= 24'h000000;
        end else if (CE_IN) begin
          lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
          if (tick) begin
            pace <= BIT_PERIOD + (SPREAD_EN_IN[g] ? {5'h00, lfsr[2:0]} : 8'h00);
          end else begin
            pace <= pace - 8'h01;
          end
          if (take) begin
            TX_DATA_OUT[24*g+23:24*g] <= {tx_msg, crc_calc(tx_msg, mlen, clen)};
            TX_VALID_OUT[g]           <= 1'b1;
          end else if (TX_READY_IN[g]) begin
            TX_VALID_OUT[g] <= 1'b0;
          end
          // error flag: a new error wins over the clearing read
          if (rx_push && clen != 4'h0 && crc_calc(rx_msg, mlen, clen) != rx_crc) begin
            crc_err[g] <= 1'b1;
          end else if (pop_rx[g]) begin
            crc_err[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule // dbsp_port

// File: core/dbsp_defines.vh
// constants of the dual sensor-bus master serial port
`ifndef DBSP_DEFINES_VH
`define DBSP_DEFINES_VH
`define DBSP_CHANNELS      2
`define DBSP_FIFO_DEPTH    4
`define DBSP_FIFO_AW       2
`define DBSP_MSG_MIN       5'h08
`define DBSP_MSG_MAX       5'h10
`define DBSP_CRC_MAX       4'h8
`define DBSP_WORD_W        24
`define DBSP_CMD_WRITE_BIT 7
`define DBSP_CMD_CHAN_BIT  0
`define DBSP_FRAME_BYTES   2'h3
`define DBSP_CRC_POLY      8'h07
`define DBSP_BIT_PERIOD    8'h20
`define DBSP_LFSR_SEED     8'h5a
`endif

// File: core/dbsp_fifo.v
// flip-flop fifo with valid and ready on both sides
module dbsp_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire             en_in,
  input  wire             in_valid_in,
  output reg              in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output reg              out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      cnt;
  wire            push = in_valid_in & in_ready_out;
  wire            pop  = out_valid_out & out_ready_in;
  wire [AW:0]     next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  integer         i;

  assign out_data_out = mem[rd_ptr];

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr        <= {AW{1'b0}};
      rd_ptr        <= {AW{1'b0}};
      cnt           <= {(AW+1){1'b0}};
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
    end else if (en_in) begin
      if (push) begin
        mem[wr_ptr] <= in_data_in;
        wr_ptr      <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      cnt           <= next_cnt;
      in_ready_out  <= (next_cnt != DEPTH);
      out_valid_out <= (next_cnt != {(AW+1){1'b0}});
    end
  end
endmodule // dbsp_fifo

// File: bench/dbsp_port_props.sv
// concurrent checks on the serial port pins, interrupt and stream handshakes
module dbsp_port_props #(
  parameter CHANNELS = 2
) (
  input wire                   REF_CLK_IN,
  input wire                   NRST_IN,
  input wire                   CS_N_IN,
  input wire                   SCLK_IN,
  input wire                   MISO_OUT,
  input wire                   MISO_OE_OUT,
  input wire                   IRQ_N_OUT,
  input wire                   IRQ_OE_OUT,
  input wire [CHANNELS-1:0]    SEND_MASK_IN,
  input wire [CHANNELS-1:0]    RECV_MASK_IN,
  input wire [24*CHANNELS-1:0] TX_DATA_OUT,
  input wire [CHANNELS-1:0]    TX_VALID_OUT,
  input wire [CHANNELS-1:0]    TX_READY_IN,
  input wire [CHANNELS-1:0]    RX_VALID_IN,
  input wire [CHANNELS-1:0]    RX_READY_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!NRST_IN);
  a_reset_quiet: assert property (disable iff (1'b0) (!NRST_IN [*2]) |-> !MISO_OE_OUT && !IRQ_OE_OUT
    && TX_VALID_OUT == 0 && RX_READY_OUT == {CHANNELS{1'b1}}) else $error("outputs not at reset values");
  a_cs_hiz: assert property (CS_N_IN [*5] |-> !MISO_OE_OUT) else $error("data-out driven while deselected");
  a_cs_drive: assert property (!CS_N_IN [*5] |-> MISO_OE_OUT) else $error("data-out not driven in frame");
  a_miso_steady: assert property (SCLK_IN [*6] |-> $stable(MISO_OUT)) else $error("data-out moved on high clock");
  a_irq_masked: assert property ((SEND_MASK_IN == 0 && RECV_MASK_IN == 0) [*3] |-> !IRQ_OE_OUT)
    else $error("interrupt with all masks off");
  a_irq_pull: assert property (IRQ_OE_OUT |-> !IRQ_N_OUT) else $error("interrupt line driven high");
  a_rx_stall: assert property ($fell(RX_READY_OUT[0]) |-> $past(RX_VALID_IN[0])) else $error("ready fell idle");
  a_tx_hold0: assert property (TX_VALID_OUT[0] && !TX_READY_IN[0] |=> TX_VALID_OUT[0]
    && $stable(TX_DATA_OUT[23:0])) else $error("stalled word 0 lost");
  a_tx_hold1: assert property (TX_VALID_OUT[1] && !TX_READY_IN[1] |=> TX_VALID_OUT[1]
    && $stable(TX_DATA_OUT[47:24])) else $error("stalled word 1 lost");
  c_tx_stall: cover property (TX_VALID_OUT[0] && !TX_READY_IN[0]);
  c_rx_full: cover property (!RX_READY_OUT[0]);
  c_irq: cover property (IRQ_OE_OUT);
endmodule // dbsp_port_props

// File: bench/dbsp_spi_host.sv
// serial host model: chip select, serial clock and data-in, msb first
module dbsp_spi_host (
  output logic cs_n_out,
  output logic sclk_out,
  output logic mosi_out,
  input  wire  miso_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end
  task automatic xfer(input int nbits, input logic [23:0] tx, output logic [23:0] rx);
    rx = 24'h0;
    cs_n_out = 1'b0;
    #100;
    for (int i = nbits - 1; i >= 0; i--) begin
      mosi_out = tx[i];
      #62.5 sclk_out = 1'b1;
      rx[i] = miso_in;
      #62.5 sclk_out = 1'b0;
    end
    #62.5 cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #200;
  endtask
  // clock and data toggling while deselected
  task automatic noise();
    repeat (8) begin
      mosi_out = ~mosi_out;
      #62.5 sclk_out = 1'b1;
      #62.5 sclk_out = 1'b0;
    end
  endtask
endmodule // dbsp_spi_host

// File: bench/tb.sv
// bench: write rows, buffer order and stall, crc error, interrupt, reset
`include "dbsp_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic ch; logic [4:0] mlen; logic [15:0] data; logic [15:0] msg;} dbsp_row_t;
  dbsp_row_t   rows [4] = '{'{1'b0, 5'h10, 16'h1234, 16'h1234}, '{1'b1, 5'h10, 16'ha5c3, 16'ha5c3},
                            '{1'b0, 5'h08, 16'hbeef, 16'hbeef}, '{1'b1, 5'h08, 16'h7f80, 16'h7f80}};
  // message word goes out whole; the crc covers only the low length bits
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  wire         cs_n, sclk, mosi, miso, miso_oe, irq_n, irq_oe;
  logic [9:0]  msg_len = 10'h210;
  logic [1:0]  spread = 2'h2, send_mask = 2'h0, recv_mask = 2'h0, tx_ready = 2'h3, rx_valid = 2'h0, seen;
  logic [47:0] rx_data = 48'h0;
  wire  [47:0] tx_data;
  wire  [1:0]  tx_valid, rx_ready;
  logic [23:0] got;
  logic [23:0] gap;
  int          num_errors = 0, cmp_count = 0, cycles = 0;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  dbsp_port i_dbsp_port (.REF_CLK_IN(ref_clk), .NRST_IN(nrst), .CE_IN(1'b1), .CS_N_IN(cs_n), .SCLK_IN(sclk),
    .MOSI_IN(mosi), .MISO_OUT(miso), .MISO_OE_OUT(miso_oe), .IRQ_N_OUT(irq_n), .IRQ_OE_OUT(irq_oe),
    .MSG_LEN_IN(msg_len), .CRC_LEN_IN(8'h88), .SPREAD_EN_IN(spread), .SEND_MASK_IN(send_mask),
    .RECV_MASK_IN(recv_mask), .TX_DATA_OUT(tx_data), .TX_VALID_OUT(tx_valid), .TX_READY_IN(tx_ready),
    .RX_DATA_IN(rx_data), .RX_VALID_IN(rx_valid), .RX_READY_OUT(rx_ready));
  dbsp_spi_host host (.cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi), .miso_in(miso_oe ? miso : 1'bz));
  function automatic logic [7:0] crc8(input logic [15:0] m, input int mlen);
    logic [7:0] c;
    c = 8'h00;
    for (int i = mlen - 1; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic check(input logic [23:0] g, input logic [23:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wait_tx(input logic ch);
    @(negedge ref_clk);
    for (int n = 0; n < 300 && tx_valid[ch] !== 1'b1; n++) @(negedge ref_clk);
  endtask
  task automatic rx_push(input int ch, input logic [15:0] m, input logic [7:0] flip);
    @(negedge ref_clk);
    rx_data[ch*24 +: 24] = {m, crc8(m, 16) ^ flip};
    rx_valid[ch] = 1'b1;
    for (int n = 0; n < 50 && rx_ready[ch] !== 1'b1; n++) @(negedge ref_clk);
    @(negedge ref_clk);
    rx_valid[ch] = 1'b0;
  endtask
  task automatic st(input logic [7:0] e);
    host.xfer(24, 24'h0, got);
    check({got[23:16], 16'h0}, {e, 16'h0});
  endtask
  task automatic irq(input logic e);
    idle(4);
    // line level as the pull-up leaves it when released
    check({22'h0, irq_oe, irq_oe ? irq_n : 1'b1}, {22'h0, e, ~e});
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    idle(3);
    check({miso_oe, irq_oe, tx_valid, rx_ready, 18'h0}, {6'h03, 18'h0});
    nrst = 1'b1;
    idle(3);
    foreach (rows[r]) begin
      msg_len = {2{rows[r].mlen}};
      host.xfer(24, {7'h40, rows[r].ch, rows[r].data}, got);
      wait_tx(rows[r].ch);
      check(tx_data[rows[r].ch*24 +: 24], {rows[r].msg, crc8(rows[r].msg, rows[r].mlen)});
    end
    msg_len = 10'h210;
    tx_ready = 2'h2;
    host.xfer(24, 24'h801111, got);
    host.xfer(24, 24'h802222, got);
    host.xfer(24, 24'h803333, got);
    wait_tx(0);
    idle(20);
    check(tx_data[23:0], {16'h1111, crc8(16'h1111, 16)});
    tx_ready = 2'h3;
    wait_tx(0);
    check(tx_data[23:0], {16'h2222, crc8(16'h2222, 16)});
    // unspread channel: words leave exactly one pacing period apart
    gap = 24'h0;
    do begin
      @(negedge ref_clk);
      gap++;
    end while (tx_valid[0] !== 1'b1 && gap < 24'h64);
    check(gap, {16'h0, `DBSP_BIT_PERIOD} + 24'h1);
    check(tx_data[23:0], {16'h3333, crc8(16'h3333, 16)});
    for (int k = 1; k <= 4; k++) rx_push(0, 16'(16'h1111 * k), 8'h00);
    idle(3);
    check({22'h0, rx_ready}, 24'h2);
    for (int k = 1; k <= 4; k++) begin
      host.xfer(24, 24'h0, got);
      check(got, {8'h13, 16'(16'h1111 * k)});
    end
    st(8'h03);
    rx_push(1, 16'h5a5a, 8'h01);
    st(8'ha3);
    host.xfer(24, 24'h010000, got);
    check(got, 24'ha35a5a);
    st(8'h03);
    host.noise();
    host.xfer(16, 24'h0080aa, got);
    seen = 2'h0;
    repeat (80) begin
      @(negedge ref_clk);
      seen = seen | tx_valid;
    end
    check({22'h0, seen}, 24'h0);
    recv_mask = 2'h3;
    irq(1'b0);
    send_mask = 2'h1;
    irq(1'b1);
    send_mask = 2'h0;
    rx_push(0, 16'h0f0f, 8'h00);
    irq(1'b1);
    recv_mask = 2'h2;
    irq(1'b0);
    nrst = 1'b0;
    idle(2);
    check({miso_oe, irq_oe, tx_valid, rx_ready, 18'h0}, {6'h03, 18'h0});
    nrst = 1'b1;
    idle(3);
    st(8'h03);
    report_and_stop();
  end
endmodule // tb
bind dbsp_port dbsp_port_props #(.CHANNELS(CHANNELS)) i_props (.REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN),
  .CS_N_IN(CS_N_IN), .SCLK_IN(SCLK_IN), .MISO_OUT(MISO_OUT), .MISO_OE_OUT(MISO_OE_OUT), .IRQ_N_OUT(IRQ_N_OUT),
  .IRQ_OE_OUT(IRQ_OE_OUT), .SEND_MASK_IN(SEND_MASK_IN), .RECV_MASK_IN(RECV_MASK_IN), .TX_DATA_OUT(TX_DATA_OUT),
  .TX_VALID_OUT(TX_VALID_OUT), .TX_READY_IN(TX_READY_IN), .RX_VALID_IN(RX_VALID_IN), .RX_READY_OUT(RX_READY_OUT));
